// *** ppm_monitor.sv ***
// Port performance monitor: statistics counters, queue watchers, reorder counter, AXI4-Lite slave.
// Assumes event inputs come from port logic on aclk; each port instantiates its own copy.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`default_nettype none
// Behaviour
// [RULE1] One full independent register set per port
// [RULE2] Counter can count 32-bit words
// [RULE3] Counter can count whole packets
// [RULE4] Packet counting optionally filtered by priority
// [RULE5] Retried packets never counted
// [RULE6] Separate inbound and outbound depth watermarks
// [RULE7] Count crossings above watermark per direction
// [RULE8] Accumulate time above watermark, programmable units
// [RULE9] Limit passed raises interrupt and/or port-write
// [RULE10] Count packet reorders in switch fabric
// [RULE11] Reorder threshold reached triggers interrupt
// [RULE12] Performance registers are readable and writable; the OQ/IQ STAT and TIME counters ignore writes here
// [RULE13] Counters clear to zero on read
// [RULE14] Counters saturate at maximum value
// [RULE15] 32-bit counters with direction/type/priority select
// [RULE16] Event during clearing read restarts at one
module ppm_monitor
  import ppm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ppm_link_ev_t tx_ev,
  input wire ppm_link_ev_t rx_ev,
  input wire logic [PPM_QW-1:0] oq_depth,
  input wire logic [PPM_QW-1:0] iq_depth,
  input wire logic reorder_ev,
  output logic irq,
  output logic port_write_req
);
  // ----------------------------------------------------------------
  // Configuration and counter state
  // ----------------------------------------------------------------
  logic [31:0] ctl_reg [PPM_NCNT]; // [RULE1]
  logic [31:0] cnt_reg [PPM_NCNT];
  logic [31:0] oq_mark_reg;
  logic [31:0] iq_mark_reg;
  logic [31:0] rod_cnt_reg;
  logic [31:0] rod_lim_reg;
  logic [31:0] alert_reg;
  logic [31:0] oq_stat;
  logic [31:0] oq_time;
  logic [31:0] iq_stat;
  logic [31:0] iq_time;
  logic oq_over;
  logic iq_over;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [7:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_have_reg;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] rd_addr;

  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    unique case (a)
      PPM_CNT_CTL0, PPM_CNT_CTL1, PPM_CNT_CTL2, PPM_CNT_CTL3,
      PPM_CNT0, PPM_CNT1, PPM_CNT2, PPM_CNT3,
      PPM_OQ_MARK, PPM_OQ_STAT, PPM_OQ_TIME,
      PPM_IQ_MARK, PPM_IQ_STAT, PPM_IQ_TIME,
      PPM_ROD_CNT, PPM_ROD_LIM, PPM_ALERT_CTL: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Address and data are latched separately so the master may offer them in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_addr_reg) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    end
  end

  // Read mux; the read that takes a counter's value is the one that clears it.
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      PPM_CNT_CTL0: v = ctl_reg[0];
      PPM_CNT_CTL1: v = ctl_reg[1];
      PPM_CNT_CTL2: v = ctl_reg[2];
      PPM_CNT_CTL3: v = ctl_reg[3];
      PPM_CNT0: v = cnt_reg[0];
      PPM_CNT1: v = cnt_reg[1];
      PPM_CNT2: v = cnt_reg[2];
      PPM_CNT3: v = cnt_reg[3];
      PPM_OQ_MARK: v = oq_mark_reg;
      PPM_OQ_STAT: v = oq_stat;
      PPM_OQ_TIME: v = oq_time;
      PPM_IQ_MARK: v = iq_mark_reg;
      PPM_IQ_STAT: v = iq_stat;
      PPM_IQ_TIME: v = iq_time;
      PPM_ROD_CNT: v = rod_cnt_reg;
      PPM_ROD_LIM: v = rod_lim_reg;
      PPM_ALERT_CTL: v = alert_reg;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux(rd_addr); // [RULE12]
      s_axi_rresp <= mapped(rd_addr) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  function automatic logic wr_hit(input logic [7:0] a);
    return wr_fire && aw_addr_reg == a;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oq_mark_reg <= PPM_RST_VAL;
      iq_mark_reg <= PPM_RST_VAL;
      rod_lim_reg <= PPM_RST_VAL;
      alert_reg <= PPM_RST_VAL;
    end else begin
      if (wr_hit(PPM_OQ_MARK)) oq_mark_reg <= merge(oq_mark_reg, w_data_reg, w_strb_reg); // [RULE6]
      if (wr_hit(PPM_IQ_MARK)) iq_mark_reg <= merge(iq_mark_reg, w_data_reg, w_strb_reg); // [RULE6]
      if (wr_hit(PPM_ROD_LIM)) rod_lim_reg <= merge(rod_lim_reg, w_data_reg, w_strb_reg);
      if (wr_hit(PPM_ALERT_CTL)) alert_reg <= merge(alert_reg, w_data_reg, w_strb_reg);
    end
  end

  // ----------------------------------------------------------------
  // Statistics counters
  // ----------------------------------------------------------------
  // Event selection per counter from its control word. [RULE15]
  function automatic logic sel_event(input logic [31:0] ctl, input ppm_link_ev_t tx, input ppm_link_ev_t rx);
    ppm_link_ev_t e;
    logic hit;
    e = ctl[CTL_DIR] ? rx : tx;
    if (!ctl[CTL_PKT]) begin
      hit = e.word; // [RULE2]
    end else begin
      hit = e.word && e.pkt_end && !e.retried; // [RULE3] [RULE5]
      if (ctl[CTL_PFE] && e.pri != ctl[CTL_PRI_LO +: 2]) begin
        hit = 1'b0; // [RULE4]
      end
    end
    return hit;
  endfunction

  // A write loads the counter; a read clears it, with a coincident event counted as one. [RULE12]
  for (genvar i = 0; i < PPM_NCNT; i++) begin : g_cnt
    localparam logic [7:0] CTL_A = PPM_CNT_CTL0 + 8'(4 * i);
    localparam logic [7:0] CNT_A = PPM_CNT0 + 8'(4 * i);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctl_reg[i] <= PPM_RST_VAL;
      end else if (wr_hit(CTL_A)) begin
        ctl_reg[i] <= merge(ctl_reg[i], w_data_reg, w_strb_reg);
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_reg[i] <= PPM_RST_VAL;
      end else if (wr_hit(CNT_A)) begin
        cnt_reg[i] <= merge(cnt_reg[i], w_data_reg, w_strb_reg);
      end else begin
        cnt_reg[i] <= ppm_bump(cnt_reg[i], sel_event(ctl_reg[i], tx_ev, rx_ev),
                               rd_fire && rd_addr == CNT_A); // [RULE13] [RULE14] [RULE16]
      end
    end
  end

  // ----------------------------------------------------------------
  // Queue watermark watchers
  // ----------------------------------------------------------------
  ppm_queue_watch u_oq (
    .aclk(aclk),
    .aresetn(aresetn),
    .depth(oq_depth),
    .mark_cfg(oq_mark_reg),
    .rd_stat(rd_fire && rd_addr == PPM_OQ_STAT),
    .rd_time(rd_fire && rd_addr == PPM_OQ_TIME),
    .stat_reg(oq_stat),
    .time_reg(oq_time),
    .over_limit(oq_over)
  );

  ppm_queue_watch u_iq (
    .aclk(aclk),
    .aresetn(aresetn),
    .depth(iq_depth),
    .mark_cfg(iq_mark_reg),
    .rd_stat(rd_fire && rd_addr == PPM_IQ_STAT),
    .rd_time(rd_fire && rd_addr == PPM_IQ_TIME),
    .stat_reg(iq_stat),
    .time_reg(iq_time),
    .over_limit(iq_over)
  );

  // ----------------------------------------------------------------
  // Reorder counter
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rod_cnt_reg <= PPM_RST_VAL;
    end else if (wr_hit(PPM_ROD_CNT)) begin
      rod_cnt_reg <= merge(rod_cnt_reg, w_data_reg, w_strb_reg);
    end else begin
      rod_cnt_reg <= ppm_bump(rod_cnt_reg, reorder_ev, rd_fire && rd_addr == PPM_ROD_CNT); // [RULE10] [RULE13]
    end
  end

  // ----------------------------------------------------------------
  // Alerts
  // ----------------------------------------------------------------
  // Alerts are levels that follow the counts, so reading a counter to zero also drops its alert.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
      port_write_req <= 1'b0;
    end else begin
      irq <= (oq_over && alert_reg[ALR_OIRQ]) || (iq_over && alert_reg[ALR_IIRQ]) || // [RULE9]
             (alert_reg[ALR_RIRQ] && rod_lim_reg != 32'h0000_0000 && rod_cnt_reg >= rod_lim_reg); // [RULE11]
      port_write_req <= (oq_over && alert_reg[ALR_OPW]) || (iq_over && alert_reg[ALR_IPW]); // [RULE9]
    end
  end
endmodule
`default_nettype wire

// *** ppm_pkg.sv ***
// Package for the port performance monitor: register map, field layout, event carrier.
// Assumes one instance of the monitor per packet port, all on the port clock aclk.
`default_nettype none
package ppm_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PPM_CNT_CTL0 = 8'h00;
  localparam logic [7:0] PPM_CNT_CTL1 = 8'h04;
  localparam logic [7:0] PPM_CNT_CTL2 = 8'h08;
  localparam logic [7:0] PPM_CNT_CTL3 = 8'h0C;
  localparam logic [7:0] PPM_CNT0 = 8'h10;
  localparam logic [7:0] PPM_CNT1 = 8'h14;
  localparam logic [7:0] PPM_CNT2 = 8'h18;
  localparam logic [7:0] PPM_CNT3 = 8'h1C;
  localparam logic [7:0] PPM_OQ_MARK = 8'h20;
  localparam logic [7:0] PPM_OQ_STAT = 8'h24;
  localparam logic [7:0] PPM_OQ_TIME = 8'h28;
  localparam logic [7:0] PPM_IQ_MARK = 8'h30;
  localparam logic [7:0] PPM_IQ_STAT = 8'h34;
  localparam logic [7:0] PPM_IQ_TIME = 8'h38;
  localparam logic [7:0] PPM_ROD_CNT = 8'h40;
  localparam logic [7:0] PPM_ROD_LIM = 8'h44;
  localparam logic [7:0] PPM_ALERT_CTL = 8'h48;
  // ----------------------------------------------------------------
  // Field layout and sizes
  // ----------------------------------------------------------------
  localparam int PPM_NCNT = 4;
  localparam int PPM_QW = 8;
  // Counter control: [0] direction (1 = receive), [1] packets, [2] priority filter, [4:3] priority.
  localparam int CTL_DIR = 0;
  localparam int CTL_PKT = 1;
  localparam int CTL_PFE = 2;
  localparam int CTL_PRI_LO = 3;
  // Watermark register: [7:0] depth mark, [23:8] event limit, [31:24] time unit prescale.
  localparam int MARK_LIM_LO = 8;
  localparam int MARK_UNIT_LO = 24;
  // Alert control: [0] out irq en, [1] out port-write en, [2] in irq en, [3] in pw en, [4] reorder irq en.
  localparam int ALR_OIRQ = 0;
  localparam int ALR_OPW = 1;
  localparam int ALR_IIRQ = 2;
  localparam int ALR_IPW = 3;
  localparam int ALR_RIRQ = 4;
  localparam logic [31:0] PPM_RST_VAL = 32'h0000_0000;
  localparam logic [31:0] PPM_MAX = 32'hFFFF_FFFF;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  // Per-direction traffic event, one cycle per word beat.
  typedef struct packed {
    logic word;     // One 32-bit word moved on the link.
    logic pkt_end;  // Last word of a packet.
    logic retried;  // The packet ending now was retried.
    logic [1:0] pri;
  } ppm_link_ev_t;

  // Counter add: saturates and restarts on a clearing read.
  function automatic logic [31:0] ppm_bump(input logic [31:0] cur, input logic ev, input logic clr);
    logic [31:0] base;
    base = clr ? PPM_RST_VAL : cur;
    if (ev && base != PPM_MAX) begin
      base = base + 32'h0000_0001;
    end
    return base;
  endfunction
endpackage
`default_nettype wire

// *** ppm_queue_watch.sv ***
// Watermark watcher for one queue direction.
// Assumes depth comes from logic on aclk; counters clear on the read strobes given.
`default_nettype none
module ppm_queue_watch
  import ppm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PPM_QW-1:0] depth,
  input wire logic [31:0] mark_cfg,
  input wire logic rd_stat,
  input wire logic rd_time,
  output logic [31:0] stat_reg,
  output logic [31:0] time_reg,
  output logic over_limit
);
  logic above_reg;
  logic above_now;
  logic [7:0] tick_reg;
  logic unit_done;

  assign above_now = depth > mark_cfg[PPM_QW-1:0];
  assign unit_done = above_reg && (tick_reg == mark_cfg[MARK_UNIT_LO +: 8]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      above_reg <= 1'b0;
    end else begin
      above_reg <= above_now;
    end
  end

  // Count each rising crossing of the watermark. [RULE7] [RULE13] [RULE14] [RULE16]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= PPM_RST_VAL;
    end else begin
      stat_reg <= ppm_bump(stat_reg, above_now && !above_reg, rd_stat);
    end
  end

  // Time above mark, one step per (prescale+1) cycles. [RULE8]
  always_ff @(posedge aclk) begin
    if (!aresetn || !above_reg || unit_done) begin
      tick_reg <= 8'h00;
    end else begin
      tick_reg <= tick_reg + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_reg <= PPM_RST_VAL;
    end else begin
      time_reg <= ppm_bump(time_reg, unit_done, rd_time); // [RULE13] [RULE14]
    end
  end

  // Limit compare against the programmed event count. [RULE9]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      over_limit <= 1'b0;
    end else begin
      over_limit <= (mark_cfg[MARK_LIM_LO +: 16] != 16'h0000) && (stat_reg > {16'h0000, mark_cfg[MARK_LIM_LO +: 16]});
    end
  end
endmodule
`default_nettype wire

// *** ppm_monitor_props.sv ***
// Concurrent checks on the ports of the port performance monitor.
// Assumes it is bound to ppm_monitor and that the master keeps one read and one write in flight.
`default_nettype none
module ppm_monitor_props
  import ppm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire logic port_write_req
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // The gaps at 2C and 3C and anything past the alert word are refused.
  function automatic logic bad_addr(input logic [7:0] a);
    return a[1:0] != 2'b00 || a > 8'h48 || a == 8'h2C || a == 8'h3C;
  endfunction
  logic aw_bad_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) aw_bad_reg <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready) aw_bad_reg <= bad_addr(s_axi_awaddr);
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response changed before taken");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read data late");
  property p_r_cause; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready); endproperty
  a_r_cause: assert property (p_r_cause) else $error("read data without request");
  property p_r_bad;
    s_axi_arvalid && s_axi_arready && bad_addr(s_axi_araddr) |=>
      s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_r_bad: assert property (p_r_bad) else $error("unmapped read not refused");
  property p_r_good; s_axi_arvalid && s_axi_arready && !bad_addr(s_axi_araddr) |=> s_axi_rresp == AXI_OKAY; endproperty
  a_r_good: assert property (p_r_good) else $error("mapped read refused");
  property p_b_resp; s_axi_bvalid |-> s_axi_bresp == (aw_bad_reg ? AXI_SLVERR : AXI_OKAY); endproperty
  a_b_resp: assert property (p_b_resp) else $error("wrong write response code");
  property p_ar_ans; s_axi_arvalid && !s_axi_rvalid |-> ##[0:2] s_axi_arready; endproperty
  a_ar_ans: assert property (p_ar_ans) else $error("read address not taken");
  property p_w_ans; s_axi_awvalid && s_axi_wvalid |-> ##[1:4] s_axi_bvalid; endproperty
  a_w_ans: assert property (p_w_ans) else $error("write not answered");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd_err: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == AXI_SLVERR);
  c_irq: cover property ($rose(irq));
  c_pw: cover property ($rose(port_write_req));
endmodule
bind ppm_monitor ppm_monitor_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq(irq), .port_write_req(port_write_req));
`default_nettype wire

// *** ppm_monitor_tb.sv ***
// Self-checking bench for the port performance monitor, driving bus, traffic and queue depths.
// Assumes the bound checker and a 100 ns clock.
`default_nettype none
module ppm_monitor_tb
  import ppm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [31:0] d; logic [1:0] r; logic [31:0] t;} ppm_exp_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reorder_ev, irq, port_write_req;
  logic [7:0] s_axi_awaddr, s_axi_araddr, oq_depth, iq_depth;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  ppm_link_ev_t tx_ev, rx_ev;
  ppm_exp_t rq[$];
  logic [1:0] bq[$];
  int err_total = 0;
  int cmp_count = 0;
  ppm_monitor dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .tx_ev(tx_ev), .rx_ev(rx_ev), .oq_depth(oq_depth), .iq_depth(iq_depth), .reorder_ev(reorder_ev), .irq(irq),
    .port_write_req(port_write_req));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // Compare tasks and response watcher
  // ----------------------------------------------------------------
  task automatic miss(input logic [31:0] g, input logic [31:0] e);
    err_total++;
    $display("unexpected at %0t: got %h expected %h", $time, g, e);
  endtask
  task automatic cmp_rd(input logic [31:0] g, input logic [1:0] gr);
    ppm_exp_t e;
    cmp_count++;
    e = (rq.size() != 0) ? rq.pop_front() : '{32'h0000_DEAD, 2'b11, 32'h0000_0000};
    // A tolerance allows for when the time accumulators start.
    if (!(gr === e.r && ^g !== 1'bx && g >= e.d && g - e.d <= e.t)) miss({g[29:0], gr}, {e.d[29:0], e.r});
  endtask
  task automatic cmp_b(input logic [1:0] gr);
    logic [1:0] e;
    cmp_count++;
    e = (bq.size() != 0) ? bq.pop_front() : 2'b11;
    if (gr !== e) miss(32'(gr), 32'(e));
  endtask
  task automatic chk_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e) miss(32'(g), 32'(e));
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) cmp_rd(s_axi_rdata, s_axi_rresp);
    if (s_axi_bvalid === 1'b1 && s_axi_bready) cmp_b(s_axi_bresp);
  end
  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r, input logic [31:0] t);
    rq.push_back('{d, r, t});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Depth sits at the mark itself between bursts, which must not count as above it.
  task automatic burst(input logic inb);
    @(posedge aclk);
    if (inb) iq_depth <= 8'h20;
    else oq_depth <= 8'h20;
    repeat (6) @(posedge aclk);
    iq_depth <= 8'h10;
    oq_depth <= 8'h10;
    repeat (3) @(posedge aclk);
  endtask
  function automatic ppm_link_ev_t rnd_ev();
    rnd_ev.word = 1'($urandom_range(1));
    rnd_ev.pkt_end = rnd_ev.word & 1'($urandom_range(1));
    rnd_ev.retried = ($urandom_range(3) == 0);
    rnd_ev.pri = 2'($urandom_range(3));
  endfunction
  function automatic logic [31:0] pk(input ppm_link_ev_t e, input logic f, input logic [1:0] p);
    return 32'(e.word && e.pkt_end && !e.retried && (!f || e.pri == p));
  endfunction
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    summarize();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] m[17];
    logic [31:0] v;
    logic [31:0] c[4];
    ppm_link_ev_t tx, rx;
    m = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h30, 8'h34, 8'h38,
          8'h40, 8'h44, 8'h48};
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, reorder_ev} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, oq_depth, iq_depth, tx_ev, rx_ev} = '0;
    s_axi_wstrb = 4'hF;
    v = $urandom(49720);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (m[i]) rd(m[i], 32'h0000_0000, AXI_OKAY, 0);
    rd(8'h4C, 32'h0000_0000, AXI_SLVERR, 0);
    rd(8'h2C, 32'h0000_0000, AXI_SLVERR, 0);
    wr(8'h50, 32'h1234_5678, AXI_SLVERR);
    v = $urandom();
    wr(PPM_CNT1, v, AXI_OKAY);
    rd(PPM_CNT1, v, AXI_OKAY, 0);
    rd(PPM_CNT1, 32'h0000_0000, AXI_OKAY, 0);
    wr(PPM_IQ_MARK, v, AXI_OKAY);
    rd(PPM_IQ_MARK, v, AXI_OKAY, 0);
    wr(PPM_CNT0, 32'hFFFF_FFFE, AXI_OKAY);
    tx_ev <= '{1'b1, 1'b0, 1'b0, 2'b00};
    repeat (3) @(posedge aclk);
    tx_ev <= '0;
    @(posedge aclk);
    rd(PPM_CNT0, PPM_MAX, AXI_OKAY, 0);
    rd(PPM_CNT0, 32'h0000_0000, AXI_OKAY, 0);
    c = '{32'h0, 32'h3, 32'h3, 32'h3};
    for (int p = 0; p < 4; p++) begin
      wr(PPM_CNT_CTL0, 32'(p % 2), AXI_OKAY);
      wr(PPM_CNT_CTL1, 32'h0000_0003, AXI_OKAY);
      wr(PPM_CNT_CTL2, 32'h0000_0006 | 32'(p << 3), AXI_OKAY);
      wr(PPM_CNT_CTL3, 32'h0000_0007 | 32'(p << 3), AXI_OKAY);
      repeat (60) begin
        @(posedge aclk);
        tx = rnd_ev();
        rx = rnd_ev();
        tx_ev <= tx;
        rx_ev <= rx;
        c[0] += 32'((p % 2 == 1) ? rx.word : tx.word);
        c[1] += pk(rx, 1'b0, 2'b00);
        c[2] += pk(tx, 1'b1, 2'(p));
        c[3] += pk(rx, 1'b1, 2'(p));
      end
      @(posedge aclk);
      tx_ev <= '0;
      rx_ev <= '0;
      repeat (2) @(posedge aclk);
      rd(PPM_CNT0, c[0], AXI_OKAY, 0);
      rd(PPM_CNT1, c[1], AXI_OKAY, 0);
      rd(PPM_CNT2, c[2], AXI_OKAY, 0);
      rd(PPM_CNT3, c[3], AXI_OKAY, 0);
      c = '{default: 32'h0000_0000};
    end
    rx_ev.word <= 1'b1;
    rd(PPM_CNT0, 32'h0000_0001, AXI_OKAY, 0);
    rx_ev.word <= 1'b0;
    rd(PPM_CNT0, 32'h0000_0003, AXI_OKAY, 0);
    wr(PPM_IQ_MARK, 32'h0100_0110, AXI_OKAY);
    wr(PPM_OQ_MARK, 32'h0000_0110, AXI_OKAY);
    wr(PPM_ALERT_CTL, 32'h0000_001F, AXI_OKAY);
    burst(1'b0);
    chk_bit(irq, 1'b0);
    burst(1'b0);
    chk_bit(irq, 1'b1);
    chk_bit(port_write_req, 1'b1);
    wr(PPM_ALERT_CTL, 32'h0000_001D, AXI_OKAY);
    repeat (2) @(posedge aclk);
    chk_bit(port_write_req, 1'b0);
    chk_bit(irq, 1'b1);
    rd(PPM_OQ_TIME, 32'h0000_000A, AXI_OKAY, 2);
    rd(PPM_OQ_STAT, 32'h0000_0002, AXI_OKAY, 0);
    repeat (2) @(posedge aclk);
    chk_bit(irq, 1'b0);
    wr(PPM_ALERT_CTL, 32'h0000_0004, AXI_OKAY);
    burst(1'b1);
    burst(1'b1);
    chk_bit(irq, 1'b1);
    chk_bit(port_write_req, 1'b0);
    rd(PPM_IQ_TIME, 32'h0000_0004, AXI_OKAY, 2);
    rd(PPM_IQ_STAT, 32'h0000_0002, AXI_OKAY, 0);
    wr(PPM_ROD_LIM, 32'h0000_0003, AXI_OKAY);
    wr(PPM_ALERT_CTL, 32'h0000_0010, AXI_OKAY);
    for (int i = 0; i < 3; i++) begin
      reorder_ev <= 1'b1;
      @(posedge aclk);
      reorder_ev <= 1'b0;
      repeat (3) @(posedge aclk);
      chk_bit(irq, i == 2);
    end
    rd(PPM_ROD_CNT, 32'h0000_0003, AXI_OKAY, 0);
    repeat (2) @(posedge aclk);
    chk_bit(irq, 1'b0);
    repeat (4) @(posedge aclk);
    summarize();
  end
endmodule
`default_nettype wire
